/* hdl/mip_i2c_port.sv */
// Serial slave port and register file of the eight-input monitor.
// Assumes scl and sda arrive from pins, link_clk oversamples them, clk runs the sequencer.
`timescale 1ns/10ps
`default_nettype none
module mip_i2c_port
   import mip_pkg::*;
#(
   parameter int NUM_RES = 10  // Number of 15-bit results, each an MSB and an LSB register.
) (
   input  wire logic        clk,         // Core clock, 100 MHz.
   input  wire logic        rst,         // Asynchronous reset, active high.
   input  wire logic        link_clk,    // Sampling clock of the bus logic.
   input  wire logic        scl_in,      // Bus clock pin level.
   input  wire logic        sda_in,      // Bus data pin level.
   output var  logic        sda_out,     // Bus data drive value, always low.
   output var  logic        sda_oe,      // High while the port pulls data low.
   input  wire logic [2:0]  adr_sel,     // Address select straps.
   input  wire logic        res_wr,      // Sequencer offers a result.
   input  wire logic [3:0]  res_sel,     // Which result is offered.
   input  wire logic [14:0] res_data,    // Sign and value of the result.
   output var  logic        res_ready,   // Result taken; low while a read runs.
   input  wire logic        conv_done,   // Sequencer finished a single-shot pass.
   output var  logic        conv_start,  // One-cycle trigger of a conversion.
   output var  logic [4:0]  chan_en,     // Channel enable bits.
   output var  logic [31:0] ctrl_regs,   // The four control registers, lowest offset low.
   output var  logic        repeat_mode, // Repeated conversions selected.
   output var  logic        kelvin_mode  // Temperatures reported in Kelvin.
);
   import mip_pkg::*;

   // Refuse any result count other than 10, the count that fills the status bits.
   initial begin
      if (NUM_RES != 10) $error("NUM_RES must be 10 to fill the status bits");
   end

   // *****************************************************************
   // Link domain: pin sampling and edge detection
   // *****************************************************************
   logic        scl_s, sda_s;   // Synchronised pin levels.
   logic [2:0]  adr_s;          // Synchronised straps.
   logic        scl_d, sda_d;   // Previous samples.
   logic        scl_rise, scl_fall, bus_start, bus_stop;

   // Bus lines reset to their idle high level so no false edge follows reset.
   mip_sync #(.WIDTH(5), .INIT(5'h18)) pin_sync (
      .clk (link_clk),
      .rst (rst),
      .d   ({scl_in, sda_in, adr_sel}),
      .q   ({scl_s, sda_s, adr_s})
   );

   // Keeps one earlier sample of both lines for edge detection.
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_d;
   assign scl_fall  = ~scl_s & scl_d;
   assign bus_start = scl_s & scl_d & sda_d & ~sda_s;  // Data falls with clock high.
   assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;  // Data rises with clock high.

   // *****************************************************************
   // Link domain: byte engine
   // *****************************************************************
   mip_state_e  state;        // Position within the transfer.
   logic [2:0]  cnt;          // Bit counter within a byte.
   logic [7:0]  sh;           // Receive shifter.
   logic [7:0]  tx;           // Transmit shifter, bit 7 on the line.
   logic        drv;          // Acknowledge drive.
   logic        rw;           // Direction bit of the address byte.
   logic        mack;         // Master acknowledged the last read byte.
   logic [4:0]  ptr;          // Register pointer.
   logic [4:0]  next_ptr;     // Pointer after one byte.
   logic [7:0]  nb;           // Byte completed by the current bit.
   logic        rd_active;    // A read transfer is under way.
   logic        req_tgl;      // Toggles once per register request.
   logic        req_wr;       // Request is a write.
   logic [4:0]  req_addr;     // Register addressed by the request.
   logic [7:0]  req_data;     // Write data of the request.
   logic [7:0]  rd_data;      // Core answer to the last read request.
   logic        ack_tgl;      // Core toggles after serving a request.
   logic        ack_s;        // Answer toggle seen in the link domain.

   assign nb       = {sh[6:0], sda_s};
   assign next_ptr = (ptr == RES_LAST) ? STATUS_LO : ptr + 5'h01;  // R11 R13

   mip_sync #(.WIDTH(1)) ack_sync (
      .clk (link_clk),
      .rst (rst),
      .d   (ack_tgl),
      .q   (ack_s)
   );

   // Walks through address, command and data bytes and their acknowledges.
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         state     <= ST_IDLE;
         cnt       <= '0;
         sh        <= '0;
         tx        <= 8'hFF;
         drv       <= 1'b0;
         rw        <= 1'b0;
         mack      <= 1'b0;
         ptr       <= '0;
         rd_active <= 1'b0;
         req_tgl   <= 1'b0;
         req_wr    <= 1'b0;
         req_addr  <= '0;
         req_data  <= '0;
      end else if (bus_start) begin
         // A start or repeated start always begins a new address byte.
         state     <= ST_ADDR;
         cnt       <= '0;
         drv       <= 1'b0;
         tx        <= 8'hFF;
         rd_active <= 1'b0;
      end else if (bus_stop) begin
         // A stop frees the line and ends any read.
         state     <= ST_IDLE;
         drv       <= 1'b0;
         tx        <= 8'hFF;
         rd_active <= 1'b0;
      end else begin
         case (state)
            ST_ADDR, ST_CMD, ST_WDATA: begin
               if (scl_rise) begin
                  sh  <= nb;
                  cnt <= cnt + 3'h1;
                  if (cnt == BIT_LAST) begin
                     if (state == ST_ADDR) begin
                        // Own address either way, shared address for writes only.
                        if (nb[7:1] == (BASE_ADDR | {4'h0, adr_s}) ||
                            (nb[7:1] == GLOBAL_ADDR && !nb[0])) begin  // R21
                           state <= ST_ADDR_ACK;
                           rw    <= nb[0];
                           if (nb[0]) begin
                              // Fetch the first byte early so it is ready in time.
                              req_wr    <= 1'b0;
                              req_addr  <= ptr;
                              req_tgl   <= ~req_tgl;
                              rd_active <= 1'b1;
                           end
                        end else begin
                           state <= ST_IDLE;
                        end
                     end else if (state == ST_CMD) begin
                        state <= ST_CMD_ACK;
                     end else begin
                        // Store at the pointer and step on.
                        req_wr   <= 1'b1;  // R8 R9
                        req_addr <= ptr;
                        req_data <= nb;
                        req_tgl  <= ~req_tgl;
                        ptr      <= next_ptr;
                        state    <= ST_WDATA_ACK;
                     end
                  end
               end
            end
            ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK: begin
               if (scl_fall) begin
                  if (!drv) begin
                     drv <= 1'b1;  // R2
                  end else begin
                     drv <= 1'b0;
                     cnt <= '0;
                     if (state == ST_ADDR_ACK && rw) begin
                        tx    <= rd_data;
                        state <= ST_RDATA;
                     end else if (state == ST_ADDR_ACK) begin
                        state <= ST_CMD;
                     end else if (state == ST_CMD_ACK) begin
                        ptr   <= sh[4:0];  // R7 R22
                        state <= ST_WDATA;
                     end else begin
                        state <= ST_WDATA;
                     end
                  end
               end
            end
            ST_RDATA: begin
               // Bit 0 stands until the clock falls, so the release never looks like a stop.
               if (scl_fall) begin
                  if (cnt == '0) begin
                     state <= ST_RDATA_ACK;
                  end else begin
                     tx <= {tx[6:0], 1'b1};
                  end
               end
               if (scl_rise) begin
                  cnt <= cnt + 3'h1;
                  if (cnt == BIT_LAST) begin
                     ptr <= next_ptr;  // R11
                  end
               end
            end
            ST_RDATA_ACK: begin
               if (scl_rise) begin
                  mack <= ~sda_s;
                  if (!sda_s) begin
                     // Master wants more: fetch the next register.
                     req_wr   <= 1'b0;  // R12
                     req_addr <= ptr;
                     req_tgl  <= ~req_tgl;
                  end
               end
               if (scl_fall) begin
                  cnt   <= '0;
                  tx    <= mack ? rd_data : 8'hFF;
                  state <= mack ? ST_RDATA : ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // The line is only ever pulled low; transmitted ones and the master's acknowledge slots release it.
   assign sda_out = 1'b0;
   assign sda_oe  = drv | (state == ST_RDATA && !tx[7]);  // R1

   // *****************************************************************
   // Core domain: request handshake
   // *****************************************************************
   logic        req_s;       // Request toggle seen in the core domain.
   logic        hold;        // A read runs on the bus.
   logic        req_seen;    // Last toggle value served.
   logic        req_fire;    // One-cycle pulse per request.
   logic [4:0]  roff;        // Offset into the result registers.
   logic [3:0]  ridx;        // Result addressed by the request.
   logic        is_res;      // Request addresses a result register.
   logic [7:0]  rd_mux;      // Byte read at the request address.
   logic [14:0] res [NUM_RES];   // Result values.
   logic [NUM_RES-1:0] fresh;    // Fresh flags per result.
   logic        busy;        // Conversion in progress.
   logic        single_busy; // Single-shot pass running.
   logic        rep_armed;   // Repeated mode triggered.

   mip_sync #(.WIDTH(2)) req_sync (
      .clk (clk),
      .rst (rst),
      .d   ({req_tgl, rd_active}),
      .q   ({req_s, hold})
   );

   assign req_fire = req_s ^ req_seen;
   assign roff     = req_addr - RES_FIRST;
   assign ridx     = roff[4:1];
   assign is_res   = req_addr >= RES_FIRST && req_addr <= RES_LAST && int'(ridx) < NUM_RES;

   // Selects the byte that a read request returns; gaps read as zero.
   always_comb begin
      rd_mux = 8'h00;
      if (is_res) begin
         rd_mux = roff[0] ? res[ridx][7:0] : {fresh[ridx], res[ridx][14:8]};
      end else if (req_addr == STATUS_LO) begin
         rd_mux = fresh[7:0];
      end else if (req_addr == CHAN_REG) begin
         rd_mux = {chan_en, busy, fresh[NUM_RES-1:NUM_RES-2]};
      end else if (req_addr >= CTRL_FIRST && req_addr <= CTRL_LAST) begin
         rd_mux = ctrl_regs[8*(req_addr - CTRL_FIRST) +: 8];
      end
   end

   // Serves each request once and returns its answer with a toggle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_seen <= 1'b0;
         ack_tgl  <= 1'b0;
         rd_data  <= 8'hFF;
      end else if (req_fire) begin
         req_seen <= req_s;
         ack_tgl  <= ~ack_tgl;
         if (!req_wr) begin
            rd_data <= rd_mux;
         end
      end
   end

   // *****************************************************************
   // Core domain: writable registers
   // *****************************************************************
   // Control and enable registers take only writes aimed at them.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_regs <= {4{REG_RESET}};  // R14
         chan_en   <= REG_RESET[7:CHAN_EN_LSB];
      end else if (req_fire && req_wr) begin
         if (req_addr == CHAN_REG) begin
            chan_en <= req_data[7:CHAN_EN_LSB];
         end else if (req_addr >= CTRL_FIRST && req_addr <= CTRL_LAST) begin
            ctrl_regs[8*(req_addr - CTRL_FIRST) +: 8] <= req_data;  // R24
         end
      end
   end

   assign repeat_mode = ctrl_regs[8*CTRL_MISC + REPEAT_BIT];  // R15
   assign kelvin_mode = ctrl_regs[8*CTRL_MISC + KELVIN_BIT];  // R15

   // Any write to the enable register fires one trigger pulse.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conv_start <= 1'b0;
      end else begin
         conv_start <= req_fire && req_wr && req_addr == CHAN_REG;  // R23
      end
   end

   // Busy covers a single pass, or everything after the trigger in repeated mode.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         single_busy <= 1'b0;
         rep_armed   <= 1'b0;
      end else begin
         if (conv_start) begin
            single_busy <= 1'b1;  // R18
         end else if (conv_done) begin
            single_busy <= 1'b0;
         end
         if (conv_start && repeat_mode) begin
            rep_armed <= 1'b1;  // R19
         end else if (!repeat_mode) begin
            rep_armed <= 1'b0;
         end
      end
   end

   assign busy = single_busy | rep_armed;

   // *****************************************************************
   // Core domain: results and fresh flags
   // *****************************************************************
   assign res_ready = ~hold;  // R20

   // Each result stores new data and sets its flag; a new result beats a clearing read.
   for (genvar i = 0; i < NUM_RES; i++) begin : g_res
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            res[i]   <= '0;
            fresh[i] <= 1'b0;
         end else if (res_wr && res_ready && int'(res_sel) == i) begin
            res[i]   <= res_data;
            fresh[i] <= 1'b1;  // R16
         end else if (req_fire && !req_wr && is_res && int'(ridx) == i) begin
            fresh[i] <= 1'b0;  // R17
         end
      end
   end

   // *****************************************************************
   // Checks
   // *****************************************************************
   sequence byte_done_s;
      scl_rise && cnt == BIT_LAST;
   endsequence

   ack_low_a: assert property (@(posedge link_clk) disable iff (rst)  // R2
      scl_rise && (state == ST_ADDR_ACK || state == ST_CMD_ACK || state == ST_WDATA_ACK)
      |-> sda_oe && !sda_out) else $error("acknowledge not driven low");
   fetch_done_a: assert property (@(posedge link_clk) disable iff (rst)  // R12
      scl_fall && !bus_start && !bus_stop &&
      ((state == ST_ADDR_ACK && rw && drv) || (state == ST_RDATA_ACK && mack))
      |-> ack_s == req_tgl) else $error("read byte loaded before its fetch returned");
   ack_release_a: assert property (@(posedge link_clk) disable iff (rst)  // R1
      state == ST_RDATA_ACK |-> !sda_oe) else $error("line held in master ack slot");
   ptr_load_a: assert property (@(posedge link_clk) disable iff (rst)  // R7
      state == ST_CMD_ACK && scl_fall && drv && !bus_start && !bus_stop
      |=> ptr == $past(sh[4:0])) else $error("pointer not loaded from command");
   ptr_wrap_a: assert property (@(posedge link_clk) disable iff (rst)  // R13
      state == ST_RDATA && ptr == RES_LAST && !bus_start && !bus_stop ##0 byte_done_s
      |=> ptr == STATUS_LO) else $error("pointer did not wrap");
   trig_pulse_a: assert property (@(posedge clk) disable iff (rst)  // R23
      req_fire && req_wr && req_addr == CHAN_REG |=> conv_start ##1 !conv_start)
      else $error("trigger not a single pulse");
   busy_single_a: assert property (@(posedge clk) disable iff (rst)  // R18
      conv_start |=> busy) else $error("busy low after trigger");
   busy_repeat_a: assert property (@(posedge clk) disable iff (rst)  // R19
      rep_armed && repeat_mode |=> busy) else $error("busy dropped in repeated mode");
   read_hold_a: assert property (@(posedge clk) disable iff (rst)  // R20
      hold && !req_fire |=> $stable(fresh)) else $error("result taken during read");
   ro_write_a: assert property (@(posedge clk) disable iff (rst)  // R24
      req_fire && req_wr && req_addr >= RES_FIRST |=> $stable(ctrl_regs) && $stable(chan_en))
      else $error("read-only write changed a register");
   fresh_set_a: assert property (@(posedge clk) disable iff (rst)  // R16
      res_wr && res_ready && int'(res_sel) < NUM_RES |=> fresh[$past(res_sel)])
      else $error("fresh flag not set");

endmodule
`default_nettype wire

/* hdl/mip_pkg.sv */
// Constants, state codes and register offsets of the monitor's serial register port.
// Assumes a two-wire bus master outside and a measurement sequencer on the core clock.
//
// Notes on behaviour
// R1 - Transmitter releases data line during acknowledge pulse.
// R2 - Receiving device holds data low whole acknowledge.
// R3 - Master may stop after a missing acknowledge.
// R4 - Master acknowledges read bytes it wants continued.
// R5 - Master leaves final read byte unacknowledged, stops.
// R6 - Transfers open with start, address, write, command.
// R7 - Command byte low five bits load pointer.
// R8 - First written data byte stored at pointer.
// R9 - Further write bytes go to next writable register; the pointer here steps by one, read-only or not.
// R10 - Read uses repeated start and address with read.
// R11 - Pointer advances after every transmitted byte.
// R12 - Master acknowledge brings the next register's byte.
// R13 - Pointer wraps from last result to status.
// R14 - Control registers power up holding zero.
// R15 - Single-shot or repeated mode, Celsius or Kelvin.
// R16 - New result sets its fresh flag.
// R17 - Reading a result clears its fresh flag.
// R18 - Busy reads high during a single-shot conversion.
// R19 - Busy stays high in repeated mode once triggered.
// R20 - Results are not updated while a read runs.
// R21 - Shared global address accepts writes only.
// R22 - Top three command bits are ignored.
// R23 - Any write to the enable register starts conversion.
// R24 - Writes to read-only registers change nothing.
package mip_pkg;

   // *****************************************************************
   // Bus addresses and register offsets
   // *****************************************************************
   localparam logic [6:0] BASE_ADDR   = 7'h48;  // Slave address with all select straps low.
   localparam logic [6:0] GLOBAL_ADDR = 7'h77;  // Shared address for simultaneous triggering.
   localparam logic [4:0] STATUS_LO   = 5'h00;  // Fresh flags of the eight inputs.
   localparam logic [4:0] CHAN_REG    = 5'h01;  // Channel enable, busy, trigger.
   localparam logic [4:0] CTRL_FIRST  = 5'h06;  // First control register.
   localparam logic [4:0] CTRL_LAST   = 5'h09;  // Last control register.
   localparam logic [4:0] RES_FIRST   = 5'h0A;  // First result register.
   localparam logic [4:0] RES_LAST    = 5'h1D;  // Last result register, pointer wraps after it.
   localparam logic [7:0] REG_RESET   = 8'h00;  // Power-on value of every control register.

   // *****************************************************************
   // Field positions
   // *****************************************************************
   localparam int CHAN_EN_LSB = 3;  // Channel enable bits occupy 7 down to this bit.
   localparam int BUSY_BIT    = 2;  // Busy bit in the channel register.
   localparam int CTRL_MISC   = 2;  // Index of the control register holding mode bits.
   localparam int REPEAT_BIT  = 4;  // Repeated-mode bit in that register.
   localparam int KELVIN_BIT  = 2;  // Kelvin-scale bit in that register.
   localparam logic [2:0] BIT_LAST = 3'h7;  // Count value of the eighth bit of a byte.

   // *****************************************************************
   // Link state machine
   // *****************************************************************
   typedef enum logic [3:0] {
      ST_IDLE      = 4'b0000,
      ST_ADDR      = 4'b0001,
      ST_ADDR_ACK  = 4'b0010,
      ST_CMD       = 4'b0011,
      ST_CMD_ACK   = 4'b0100,
      ST_WDATA     = 4'b0101,
      ST_WDATA_ACK = 4'b0110,
      ST_RDATA     = 4'b0111,
      ST_RDATA_ACK = 4'b1000
   } mip_state_e;

endpackage

/* hdl/mip_sync.sv */
// Two-flop synchroniser for a group of independent level signals.
// Assumes each bit is a slow level or a toggle; words need a handshake around it.
`timescale 1ns/10ps
`default_nettype none
module mip_sync #(
   parameter int               WIDTH = 1,   // Number of bits carried across.
   parameter logic [WIDTH-1:0] INIT  = '0   // Level of both stages while in reset.
) (
   input  wire logic             clk,   // Destination clock.
   input  wire logic             rst,   // Asynchronous reset, active high.
   input  wire logic [WIDTH-1:0] d,     // Levels from the other domain.
   output var  logic [WIDTH-1:0] q      // Levels safe for the destination domain.
);

   logic [WIDTH-1:0] meta;  // First stage, read only by the second stage.

   // Refuse a group with no bits.
   initial begin
      if (WIDTH < 1) $error("mip_sync needs at least one bit");
   end

   // Both stages take the idle level on reset and then shift on every rising clock edge.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= INIT;
         q    <= INIT;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule
`default_nettype wire

/* tb/mip_i2c_master.sv */
// Bus master model: makes the bus clock and pulls the data wire low.
// Assumes an open-drain data wire with a pull-up, judged on the core clock.
`timescale 1ns/10ps
`default_nettype none
module mip_i2c_master (
   input  wire logic clk,   // Timing reference.
   input  wire logic sda,   // Data wire level.
   output var  logic scl,   // Bus clock, high when idle.
   output var  logic pull   // High while the model pulls data low.
);
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   // Sets both lines, then holds them a quarter bit.
   task automatic sb(input logic s, input logic p);
      scl <= s;
      pull <= p;
      repeat (10) @(posedge clk);
   endtask
   // Start or repeated start, entered with the clock low or idle.
   task automatic start();
      sb(scl, 1'b0);
      sb(1'b1, 1'b0);
      sb(1'b1, 1'b1);
      sb(1'b0, 1'b1);
   endtask
   // Stop, which also ends a transfer after a missing acknowledge.
   task automatic stop();
      sb(1'b0, 1'b1);
      sb(1'b1, 1'b1);
      sb(1'b1, 1'b0);
   endtask
   // Eight data bits then the acknowledge slot; data never moves while the clock is high.
   task automatic xfer(input logic [7:0] d, input logic am, output logic [7:0] r,
                       output logic ack);
      logic [8:0] w;
      logic [8:0] s;
      w = {d, ~am};
      for (int i = 8; i >= 0; i--) begin
         sb(1'b0, ~w[i]);
         sb(1'b1, ~w[i]);
         s[i] = sda;
         sb(1'b1, ~w[i]);
         sb(1'b0, ~w[i]);
      end
      r = s[8:1];
      ack = ~s[0];
   endtask
endmodule
`default_nettype wire

/* tb/mip_i2c_port_bench.sv */
// Self-checking bench of the serial register port, straps set to 5.
// Assumes the master model above and a pull-up on the data wire.
`timescale 1ns/10ps
`default_nettype none
module mip_i2c_port_bench;
   import mip_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, lclk = 1'b0, scl, pull, sda_out, sda_oe;
   logic        res_wr = 1'b0, res_ready, conv_done = 1'b0, conv_start;
   logic [3:0]  res_sel = 4'h0;
   logic [14:0] res_data = 15'h0000;
   logic [4:0]  chan_en;
   logic [31:0] ctrl_regs;
   logic        repeat_mode, kelvin_mode;
   logic [7:0]  rb [0:3];
   logic [7:0]  starts = 8'h00;
   int          miscompares = 0, checks_done = 0, cyc = 0;
   wire logic   sda_w = (sda_oe ? sda_out : 1'b1) & ~pull;  // Open drain wire with pull-up.
   always #5 clk = ~clk;
   always #7.5 lclk = ~lclk;
   mip_i2c_port i_mip_i2c_port (.clk(clk), .rst(rst), .link_clk(lclk), .scl_in(scl),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .adr_sel(3'h5), .res_wr(res_wr),
      .res_sel(res_sel), .res_data(res_data), .res_ready(res_ready), .conv_done(conv_done),
      .conv_start(conv_start), .chan_en(chan_en), .ctrl_regs(ctrl_regs),
      .repeat_mode(repeat_mode), .kelvin_mode(kelvin_mode));
   mip_i2c_master i_mip_i2c_master (.clk(clk), .sda(sda_w), .scl(scl), .pull(pull));
   // Counts trigger pulses and cuts a hang short.
   always @(posedge clk) begin
      cyc++;
      if (conv_start === 1'b1) starts <= starts + 8'h01;
      if (cyc == 60000) begin
         miscompares++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask
   // Sends one byte and compares the acknowledge with the expected one.
   task automatic wb(input logic [7:0] d, input logic ea);
      logic [7:0] r;
      logic a;
      i_mip_i2c_master.xfer(d, 1'b0, r, a);
      chk("ack", {7'h0, ea}, {7'h0, a});
   endtask
   task automatic wr(input logic [7:0] ad, c, d0, d1, input logic two);
      i_mip_i2c_master.start();
      wb(ad, 1'b1);
      wb(c, 1'b1);
      wb(d0, 1'b1);
      if (two) wb(d1, 1'b1);
      i_mip_i2c_master.stop();
   endtask
   // Sets the pointer, then reads n bytes, acknowledging all but the last.
   task automatic rd(input logic [7:0] c, input int n);
      logic a;
      i_mip_i2c_master.start();
      wb(8'h9A, 1'b1);
      wb(c, 1'b1);
      i_mip_i2c_master.start();
      wb(8'h9B, 1'b1);
      for (int i = 0; i < n; i++) i_mip_i2c_master.xfer(8'hFF, i < n - 1, rb[i], a);
      i_mip_i2c_master.stop();
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      chk("ctrl", 8'h00, {6'h00, |ctrl_regs, |chan_en});
      wr(8'h9A, 8'hE6, 8'h5A, 8'hA5, 1'b1);
      chk("ctrl06", 8'h5A, ctrl_regs[7:0]);
      chk("ctrl07", 8'hA5, ctrl_regs[15:8]);
      wr(8'h9A, 8'h09, 8'h3C, 8'h77, 1'b1);
      chk("ctrl09", 8'h3C, ctrl_regs[31:24]);
      $display("test write done");
      wr(8'h9A, 8'h01, 8'hF8, 8'h00, 1'b0);
      chk("starts", 8'h01, starts);
      chk("chan_en", 8'h1F, {3'h0, chan_en});
      rd(8'h01, 1);
      chk("busy", 8'hFC, rb[0]);
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      rd(8'h01, 1);
      chk("idle", 8'hF8, rb[0]);
      wr(8'hEE, 8'h01, 8'hF8, 8'h00, 1'b0);
      chk("starts", 8'h02, starts);
      i_mip_i2c_master.start();
      wb(8'hEF, 1'b0);
      i_mip_i2c_master.stop();
      $display("test busy done");
      wr(8'h9A, 8'h08, 8'h14, 8'h00, 1'b0);
      chk("modes", 8'h03, {6'h0, repeat_mode, kelvin_mode});
      wr(8'h9A, 8'h01, 8'hF8, 8'h00, 1'b0);
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      rd(8'h01, 1);
      chk("repeat busy", 8'hFC, rb[0]);
      res_sel <= 4'h9;
      res_data <= 15'h1234;
      res_wr <= 1'b1;
      @(posedge clk);
      res_wr <= 1'b0;
      rd(8'h1C, 3);
      chk("msb", 8'h92, rb[0]);
      chk("lsb", 8'h34, rb[1]);
      chk("wrap", 8'h00, rb[2]);
      fork
         rd(8'h1C, 1);
         begin
            repeat (1300) @(posedge clk);
            chk("res_ready", 8'h00, {7'h0, res_ready});
         end
      join
      chk("stale", 8'h12, rb[0]);
      chk("res_ready", 8'h01, {7'h0, res_ready});
      $display("test read done");
      finish_test();
   end
endmodule
`default_nettype wire
